//--- latch_ref_pkg.sv
// constants and carrier types for the comparator latch and reference control
package latch_ref_pkg;

	// register byte offsets on the register bus
	localparam logic [3:0] LATCH_CONTROL_OFS   = 4'h0;
	localparam logic [3:0] LATCH_PRESCALE_OFS  = 4'h4;
	localparam logic [3:0] REFERENCE_CTRL_OFS  = 4'h8;
	localparam logic [3:0] LATCH_STATUS_OFS    = 4'hC;

	// latch_control fields
	localparam int OUT2_ROUTE_BIT     = 7;
	localparam int OUT1_ROUTE_BIT     = 6;
	localparam int CMP1_SET_EN_BIT    = 5;
	localparam int CMP2_RST_EN_BIT    = 4;
	localparam int SET_PULSE_BIT      = 3;
	localparam int RESET_PULSE_BIT    = 2;
	localparam int SET_CLK_EN_BIT     = 0;
	localparam logic [7:0] LATCH_CONTROL_RESET = 8'h00;

	// latch_clock_prescale fields
	localparam int PRESCALE_MSB       = 7;
	localparam int PRESCALE_LSB       = 6;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;
	localparam logic [5:0] PRESCALE_BASE  = 6'h04;

	// reference_control fields
	localparam int CMP1_LADDER_BIT    = 7;
	localparam int CMP2_LADDER_BIT    = 6;
	localparam int RANGE_SEL_BIT      = 5;
	localparam int FIXED_REF_EN_BIT   = 4;
	localparam int LEVEL_MSB          = 3;
	localparam int LEVEL_LSB          = 0;
	localparam logic [7:0] REFERENCE_CTRL_RESET = 8'h00;

	// latch_status fields
	localparam int STAT_CMP1_BIT      = 0;
	localparam int STAT_CMP2_BIT      = 1;
	localparam int STAT_LATCH_BIT     = 2;
	localparam int STAT_LADDER_BIT    = 3;

	// ladder tap in units of supply/96
	localparam logic [6:0] TAP_HIGH_BASE  = 7'h18;

	// reference steering handed to the analog side
	typedef struct packed {
		logic       ladder_power;
		logic       ladder_clamp;
		logic       cmp1_ladder_sel;
		logic       cmp2_ladder_sel;
		logic       fixed_ref_enable;
		logic       ladder_range_sel;
		logic [3:0] ladder_level;
		logic [6:0] ladder_tap;
	} ref_ctrl_t;

	localparam ref_ctrl_t REF_CTRL_RESET = '0;

endpackage

//--- set_clock_div.sv
// prescaling divider producing the periodic latch set tick
`timescale 1ns/1ns
module set_clock_div
	import latch_ref_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       enable_i,
	input  wire logic [1:0] prescale_i,
	output logic            tick_o
);
	logic [5:0] count_ff;
	logic [5:0] terminal;

	assign terminal = 6'((PRESCALE_BASE << prescale_i) - 6'h01);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_ff <= 6'h00;
		else if (!enable_i || count_ff >= terminal)
			count_ff <= 6'h00;
		else
			count_ff <= 6'(count_ff + 6'h01);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tick_o <= 1'b0;
		else
			tick_o <= enable_i && (count_ff >= terminal);
	end

endmodule // set_clock_div

//--- latch_ref_ctrl.sv
// comparator set-reset latch and reference selection with register bus
//
// Summary of operation
// - out2 path: inverted latch or comparator two
// - out1 path: latch or comparator one
// - comparator one sets latch when enabled
// - comparator two resets latch when enabled
// - set pulse bit: one pulse, self-clears
// - reset pulse bit: one pulse, self-clears
// - set clock enable pulses latch set periodically
// - prescale codes divide by 4, 8, 16, 32
// - status shows true comparator outputs
// - unimplemented bits ignore writes, read zero
// - range bit one low, zero high
// - four-bit level picks one of sixteen taps
// - comparator one reference: ladder or fixed
// - comparator two reference: ladder or fixed
// - ladder unpowered when both selects clear
// - fixed reference enable powers fixed reference
// - ladder clamped to ground when idle low zero
// - latch is reset-dominant
// - after reset outputs carry raw comparators
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module latch_ref_ctrl
	import latch_ref_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic [3:0]               address,
	input  wire logic                     read,
	input  wire logic                     write,
	input  wire logic [31:0]              writedata,
	input  wire logic [3:0]               byteenable,
	output logic [31:0]                   readdata,
	output logic                          waitrequest,
	input  wire logic                     cmp1_output_i,
	input  wire logic                     cmp2_output_i,
	output logic                          out1_path_o,
	output logic                          out2_path_o,
	output logic                          latch_q_o,
	output latch_ref_pkg::ref_ctrl_t      ref_ctrl_o
);
	import latch_ref_pkg::*;

	logic        rst_sync1_ff;
	logic        rst_n;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic        wr_accept;
	logic        wr_lane0;
	logic        out2_route_ff;
	logic        out1_route_ff;
	logic        cmp1_set_enable_ff;
	logic        cmp2_reset_enable_ff;
	logic        set_pulse_ff;
	logic        reset_pulse_ff;
	logic        set_clock_enable_ff;
	logic [1:0]  set_clock_prescale_ff;
	logic        cmp1_ladder_sel_ff;
	logic        cmp2_ladder_sel_ff;
	logic        ladder_range_sel_ff;
	logic        fixed_ref_enable_ff;
	logic [3:0]  ladder_level_ff;
	logic        latch_ff;
	logic        set_tick;
	logic        latch_set;
	logic        latch_reset;
	logic        nxt_latch;
	logic [7:0]  ctrl_view;
	logic [7:0]  presc_view;
	logic [7:0]  ref_view;
	logic [7:0]  stat_view;
	logic [31:0] nxt_rdata;
	ref_ctrl_t   nxt_ref;
	ref_ctrl_t   ref_ff;
	logic        out1_ff;
	logic        out2_ff;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_sync1_ff <= 1'b0;
			rst_n        <= 1'b0;
		end
		else
		begin
			rst_sync1_ff <= 1'b1;
			rst_n        <= rst_sync1_ff;
		end
	end

	// bus slave: one wait cycle, then accept
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			wait_ff <= 1'b1;
		else if ((read || write) && wait_ff)
			wait_ff <= 1'b0;
		else
			wait_ff <= 1'b1;
	end

	assign waitrequest = wait_ff;
	assign wr_accept   = write && !wait_ff;
	assign wr_lane0    = wr_accept && byteenable[0];

	// latch_control register
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out2_route_ff        <= LATCH_CONTROL_RESET[OUT2_ROUTE_BIT];
			out1_route_ff        <= LATCH_CONTROL_RESET[OUT1_ROUTE_BIT];
			cmp1_set_enable_ff   <= LATCH_CONTROL_RESET[CMP1_SET_EN_BIT];
			cmp2_reset_enable_ff <= LATCH_CONTROL_RESET[CMP2_RST_EN_BIT];
			set_clock_enable_ff  <= LATCH_CONTROL_RESET[SET_CLK_EN_BIT];
		end
		else if (wr_lane0 && address == LATCH_CONTROL_OFS)
		begin
			out2_route_ff        <= writedata[OUT2_ROUTE_BIT];
			out1_route_ff        <= writedata[OUT1_ROUTE_BIT];
			cmp1_set_enable_ff   <= writedata[CMP1_SET_EN_BIT];
			cmp2_reset_enable_ff <= writedata[CMP2_RST_EN_BIT];
			set_clock_enable_ff  <= writedata[SET_CLK_EN_BIT];
		end
	end

	// self-clearing pulse bits, one clock high
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			set_pulse_ff   <= 1'b0;
			reset_pulse_ff <= 1'b0;
		end
		else
		begin
			set_pulse_ff   <= wr_lane0 && address == LATCH_CONTROL_OFS
				&& writedata[SET_PULSE_BIT];
			reset_pulse_ff <= wr_lane0 && address == LATCH_CONTROL_OFS
				&& writedata[RESET_PULSE_BIT];
		end
	end

	// latch_clock_prescale register
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			set_clock_prescale_ff <= PRESCALE_RESET;
		else if (wr_lane0 && address == LATCH_PRESCALE_OFS)
			set_clock_prescale_ff <= writedata[PRESCALE_MSB:PRESCALE_LSB];
	end

	// reference_control register
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp1_ladder_sel_ff  <= REFERENCE_CTRL_RESET[CMP1_LADDER_BIT];
			cmp2_ladder_sel_ff  <= REFERENCE_CTRL_RESET[CMP2_LADDER_BIT];
			ladder_range_sel_ff <= REFERENCE_CTRL_RESET[RANGE_SEL_BIT];
			fixed_ref_enable_ff <= REFERENCE_CTRL_RESET[FIXED_REF_EN_BIT];
			ladder_level_ff     <= REFERENCE_CTRL_RESET[LEVEL_MSB:LEVEL_LSB];
		end
		else if (wr_lane0 && address == REFERENCE_CTRL_OFS)
		begin
			cmp1_ladder_sel_ff  <= writedata[CMP1_LADDER_BIT];
			cmp2_ladder_sel_ff  <= writedata[CMP2_LADDER_BIT];
			ladder_range_sel_ff <= writedata[RANGE_SEL_BIT];
			fixed_ref_enable_ff <= writedata[FIXED_REF_EN_BIT];
			ladder_level_ff     <= writedata[LEVEL_MSB:LEVEL_LSB];
		end
	end

	// periodic set tick from the system clock
	set_clock_div u_set_clock_div (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n),
		.enable_i   (set_clock_enable_ff),
		.prescale_i (set_clock_prescale_ff),
		.tick_o     (set_tick)
	);

	// latch inputs and reset-dominant update
	assign latch_set = (cmp1_set_enable_ff && cmp1_output_i)
		|| set_pulse_ff
		|| (set_clock_enable_ff && set_tick);
	assign latch_reset = (cmp2_reset_enable_ff && cmp2_output_i)
		|| reset_pulse_ff;

	always_comb
	begin
		if (latch_reset)
			nxt_latch = 1'b0;
		else if (latch_set)
			nxt_latch = 1'b1;
		else
			nxt_latch = latch_ff;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			latch_ff <= 1'b0;
		else
			latch_ff <= nxt_latch;
	end

	// output path multiplexers
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out1_ff <= 1'b0;
			out2_ff <= 1'b0;
		end
		else
		begin
			out1_ff <= out1_route_ff ? latch_ff : cmp1_output_i;
			out2_ff <= out2_route_ff ? !latch_ff : cmp2_output_i;
		end
	end

	assign out1_path_o = out1_ff;
	assign out2_path_o = out2_ff;
	assign latch_q_o   = latch_ff;

	// reference steering and ladder tap
	always_comb
	begin
		nxt_ref = REF_CTRL_RESET;
		nxt_ref.cmp1_ladder_sel  = cmp1_ladder_sel_ff;
		nxt_ref.cmp2_ladder_sel  = cmp2_ladder_sel_ff;
		nxt_ref.ladder_power     = cmp1_ladder_sel_ff || cmp2_ladder_sel_ff;
		nxt_ref.fixed_ref_enable = fixed_ref_enable_ff;
		nxt_ref.ladder_range_sel = ladder_range_sel_ff;
		nxt_ref.ladder_level     = ladder_level_ff;
		nxt_ref.ladder_clamp     = !nxt_ref.ladder_power && ladder_range_sel_ff
			&& ladder_level_ff == 4'h0;
		if (ladder_range_sel_ff)
			nxt_ref.ladder_tap = {1'b0, ladder_level_ff, 2'b00};
		else
			nxt_ref.ladder_tap = 7'(TAP_HIGH_BASE
				+ 7'(ladder_level_ff) * 7'h03);
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			ref_ff <= REF_CTRL_RESET;
		else
			ref_ff <= nxt_ref;
	end

	assign ref_ctrl_o = ref_ff;

	// read views; unimplemented bits are zero
	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[OUT2_ROUTE_BIT]  = out2_route_ff;
		ctrl_view[OUT1_ROUTE_BIT]  = out1_route_ff;
		ctrl_view[CMP1_SET_EN_BIT] = cmp1_set_enable_ff;
		ctrl_view[CMP2_RST_EN_BIT] = cmp2_reset_enable_ff;
		ctrl_view[SET_PULSE_BIT]   = set_pulse_ff;
		ctrl_view[RESET_PULSE_BIT] = reset_pulse_ff;
		ctrl_view[SET_CLK_EN_BIT]  = set_clock_enable_ff;
		presc_view = 8'h00;
		presc_view[PRESCALE_MSB:PRESCALE_LSB] = set_clock_prescale_ff;
		ref_view = {cmp1_ladder_sel_ff, cmp2_ladder_sel_ff, ladder_range_sel_ff,
			fixed_ref_enable_ff, ladder_level_ff};
		stat_view = 8'h00;
		stat_view[STAT_CMP1_BIT]   = cmp1_output_i;
		stat_view[STAT_CMP2_BIT]   = cmp2_output_i;
		stat_view[STAT_LATCH_BIT]  = latch_ff;
		stat_view[STAT_LADDER_BIT] = ref_ff.ladder_power;
		case (address)
			LATCH_CONTROL_OFS:  nxt_rdata = {24'h000000, ctrl_view};
			LATCH_PRESCALE_OFS: nxt_rdata = {24'h000000, presc_view};
			REFERENCE_CTRL_OFS: nxt_rdata = {24'h000000, ref_view};
			LATCH_STATUS_OFS:   nxt_rdata = {24'h000000, stat_view};
			default:            nxt_rdata = 32'h00000000;
		endcase
	end

	// read data captured while waitrequest is still high
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 32'h00000000;
		else if (read && wait_ff)
			rdata_ff <= nxt_rdata;
	end

	assign readdata = rdata_ff;

	// checks
	sequence seq_ctrl_write(int b);
		wr_lane0 && address == LATCH_CONTROL_OFS && writedata[b];
	endsequence

	sequence seq_one_pulse_set;
		set_pulse_ff ##1 !set_pulse_ff;
	endsequence

	sequence seq_one_pulse_reset;
		reset_pulse_ff ##1 !reset_pulse_ff;
	endsequence

	a_set_pulse_once: assert property (@(posedge clk_i) disable iff (!rst_n)
		seq_ctrl_write(SET_PULSE_BIT) |=> seq_one_pulse_set ##0 1'b1 ##1
		(!set_pulse_ff || $past(wr_lane0, 1)))
		else $error("set pulse not a single cycle");

	a_reset_pulse_once: assert property (@(posedge clk_i) disable iff (!rst_n)
		seq_ctrl_write(RESET_PULSE_BIT) |=> seq_one_pulse_reset)
		else $error("reset pulse not a single cycle");

	a_reset_dominant: assert property (@(posedge clk_i) disable iff (!rst_n)
		latch_reset |=> !latch_ff)
		else $error("latch not cleared on reset input");

	a_cmp1_set_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
		cmp1_set_enable_ff && cmp1_output_i && !latch_reset |=> latch_ff)
		else $error("comparator one failed to set latch");

	a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		!latch_set && !latch_reset |=> $stable(latch_ff))
		else $error("latch moved without an input");

	// rst_n as antecedent skips the edge at which reset lifts
	a_out1_route: assert property (@(posedge clk_i) disable iff (!rst_n)
		rst_n |=> out1_path_o == ($past(out1_route_ff) ? $past(latch_ff)
		: $past(cmp1_output_i)))
		else $error("out1 path wrong source");

	a_out2_route: assert property (@(posedge clk_i) disable iff (!rst_n)
		rst_n |=> out2_path_o == ($past(out2_route_ff) ? !$past(latch_ff)
		: $past(cmp2_output_i)))
		else $error("out2 path wrong source");

	a_ladder_power: assert property (@(posedge clk_i) disable iff (!rst_n)
		!cmp1_ladder_sel_ff && !cmp2_ladder_sel_ff ##1 $stable(cmp1_ladder_sel_ff)
		|-> !ref_ctrl_o.ladder_power)
		else $error("ladder powered with both selects clear");

	a_clock_set_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
		!set_clock_enable_ff ##1 !set_clock_enable_ff |-> !set_tick)
		else $error("set tick while set clock disabled");

	// only a read answer carries fresh read data
	a_unused_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		read && !waitrequest |-> readdata[31:8] == 24'h000000
		&& !(readdata[1] && $past(address, 1) == LATCH_CONTROL_OFS))
		else $error("unimplemented bits read nonzero");

endmodule // latch_ref_ctrl

//--- cmp_model.sv
// behavioural comparators and pin drivers on the far side of the latch block
`timescale 1ns/1ns
module cmp_model
	import latch_ref_pkg::*;
#(
	parameter logic [6:0] FIXED_TAP = 7'h0C // fixed reference in 96ths, nominal
)
(
	input  wire logic                     clk_i,
	input  wire latch_ref_pkg::ref_ctrl_t ref_i,
	input  wire logic [6:0]               vin1_i,
	input  wire logic [6:0]               vin2_i,
	input  wire logic                     slow_i,
	input  wire logic                     fb_i,
	input  wire logic                     latch_q_i,
	input  wire logic [1:0]               path_i,
	input  wire logic [1:0]               pin_en_i,
	output logic                          cmp1_o,
	output logic                          cmp2_o,
	output logic [1:0]                    pin_o
);
	logic [6:0] ref1;
	logic [6:0] ref2;
	logic [6:0] fixed;
	logic [1:0] st1_ff;
	logic [1:0] st2_ff;
	logic       q_ff;
	assign fixed = ref_i.fixed_ref_enable ? FIXED_TAP : 7'h00;
	assign ref1 = ref_i.cmp1_ladder_sel ? ref_i.ladder_tap : fixed;
	assign ref2 = ref_i.cmp2_ladder_sel ? ref_i.ladder_tap : fixed;
	always_ff @(posedge clk_i)
	begin
		st1_ff <= {vin2_i > ref2, vin1_i > ref1};
		st2_ff <= st1_ff;
		q_ff   <= latch_q_i;
	end
	// slow mode answers one cycle later
	assign cmp1_o = slow_i ? st2_ff[0] : st1_ff[0];
	// feedback: one-cycle pulse on each latch rise
	assign cmp2_o = fb_i ? (latch_q_i && !q_ff) : (slow_i ? st2_ff[1] : st1_ff[1]);
	// pins pulled up unless enabled as outputs
	assign pin_o = (path_i & pin_en_i) | ~pin_en_i;
endmodule // cmp_model

//--- tb_top.sv
// self-checking bench for the comparator latch and reference control
`timescale 1ns/1ns
module tb_top;
	import latch_ref_pkg::*;
	localparam int LIMIT = 20000;
	logic        clk_i;
	logic        rstn_i = 1'b0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [3:0]  address = 4'h0;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] writedata = 32'h0;
	logic [6:0]  vin1 = 7'h00;
	logic [6:0]  vin2 = 7'h00;
	logic        slow = 1'b0;
	logic        fb = 1'b0;
	logic        exp_q = 1'b0;
	logic        waitrequest, cmp1, cmp2, out1, out2, latch_q, q_prev;
	logic [31:0] readdata, rd;
	logic [1:0]  pins;
	ref_ctrl_t   ref_ctrl;
	logic [7:0]  c, r;
	int          fail_count, n_compared, cyc, last_rise, gap, rises, n;
	logic [7:0]  corner [0:4] = '{8'h20, 8'h2F, 8'h0F, 8'hC0, 8'h1A};
	logic [8:0]  pulse_t [0:4] = '{9'h108, 9'h100, 9'h004, 9'h108, 9'h00C};
	logic [10:0] en_t [0:4] = '{11'h004, 11'h105, 11'h003, 11'h082, 11'h186};

	latch_ref_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cmp1_output_i(cmp1), .cmp2_output_i(cmp2),
		.out1_path_o(out1), .out2_path_o(out2), .latch_q_o(latch_q), .ref_ctrl_o(ref_ctrl));
	cmp_model model (.clk_i(clk_i), .ref_i(ref_ctrl), .vin1_i(vin1), .vin2_i(vin2),
		.slow_i(slow), .fb_i(fb), .latch_q_i(latch_q), .path_i({out2, out1}),
		.pin_en_i(2'b11), .cmp1_o(cmp1), .cmp2_o(cmp2), .pin_o(pins));

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// latch rise spacing and timeout
	always @(posedge clk_i)
	begin
		cyc++;
		if (latch_q === 1'b1 && q_prev === 1'b0)
		begin
			gap = cyc - last_rise;
			last_rise = cyc;
			rises++;
		end
		q_prev = latch_q;
		if (cyc == LIMIT)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge clk_i);
		address    <= a;
		writedata  <= {24'hA55AC3, d};
		byteenable <= be;
		read       <= !is_wr;
		write      <= is_wr;
		do
			@(posedge clk_i);
		while (waitrequest !== 1'b0);
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, 4'hF);
		chk(what, {24'h0, exp}, rd);
	endtask

	task automatic settle();
		repeat (4) @(posedge clk_i);
	endtask

	function automatic ref_ctrl_t exp_ref(input logic [7:0] v);
		ref_ctrl_t e;
		e.cmp1_ladder_sel  = v[7];
		e.cmp2_ladder_sel  = v[6];
		e.ladder_range_sel = v[5];
		e.fixed_ref_enable = v[4];
		e.ladder_level     = v[3:0];
		e.ladder_power     = v[7] | v[6];
		e.ladder_clamp     = !(v[7] | v[6]) && v[5] && v[3:0] == 4'h0;
		e.ladder_tap = v[5] ? {1'b0, v[3:0], 2'b00} : 7'h18 + 7'(v[3:0]) * 7'h03;
		return e;
	endfunction

	initial
	begin
		void'($urandom(72));
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 5; i++)
			rdchk("reset value", (i == 4) ? 4'h2 : 4'(i * 4), 8'h00);
		vin1 <= 7'h7F;
		settle();
		chk("out1 after reset", 1, out1);
		chk("out2 after reset", 0, out2);
		wr(LATCH_CONTROL_OFS, 8'hFF);
		rdchk("control", LATCH_CONTROL_OFS, 8'hF1);
		wr(LATCH_PRESCALE_OFS, 8'hFF);
		bus(1'b1, LATCH_PRESCALE_OFS, 8'h00, 4'hE);
		rdchk("prescale", LATCH_PRESCALE_OFS, 8'hC0);
		wr(4'h2, 8'hFF);
		rdchk("unmapped", 4'h2, 8'h00);
		vin1 <= 7'h00;
		for (int i = 0; i < 5; i++)
		begin
			wr(LATCH_CONTROL_OFS, pulse_t[i][7:0]);
			rdchk("pulse bits", LATCH_CONTROL_OFS, 8'h00);
			chk("latch pulse", pulse_t[i][8], latch_q);
		end
		for (int i = 0; i < 5; i++)
		begin
			vin1 <= {7{en_t[i][2]}};
			vin2 <= {7{en_t[i][1]}};
			wr(LATCH_CONTROL_OFS, en_t[i][10:3]);
			settle();
			chk("latch cmp", en_t[i][0], latch_q);
		end
		vin1 <= 7'h00;
		vin2 <= 7'h00;
		fb <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			wr(LATCH_PRESCALE_OFS, {2'(k), 6'h00});
			wr(LATCH_CONTROL_OFS, 8'h11);
			repeat (100) @(posedge clk_i);
			chk("set clock gap", 4 << k, gap);
			wr(LATCH_CONTROL_OFS, 8'h10);
		end
		settle();
		n = rises;
		repeat (80) @(posedge clk_i);
		chk("idle rises", n, rises);
		fb <= 1'b0;
		wr(LATCH_CONTROL_OFS, 8'h04);
		for (int i = 0; i < 40; i++)
		begin
			c = 8'($urandom()) & 8'hCC;
			r = (i < 5) ? corner[i] : 8'($urandom());
			vin1 <= 7'($urandom());
			vin2 <= 7'($urandom());
			slow <= 1'($urandom());
			wr(REFERENCE_CTRL_OFS, r);
			wr(LATCH_CONTROL_OFS, c);
			exp_q = c[2] ? 1'b0 : (c[3] ? 1'b1 : exp_q);
			settle();
			chk("ref ctrl", exp_ref(r), ref_ctrl);
			chk("latch", exp_q, latch_q);
			chk("out1", c[6] ? exp_q : cmp1, out1);
			chk("out2", c[7] ? !exp_q : cmp2, out2);
			chk("pins", {c[7] ? !exp_q : cmp2, c[6] ? exp_q : cmp1}, pins);
			rdchk("reference", REFERENCE_CTRL_OFS, r);
			rdchk("control", LATCH_CONTROL_OFS, c & 8'hC0);
			rdchk("status", LATCH_STATUS_OFS, {4'h0, r[7] | r[6], exp_q, cmp2, cmp1});
		end
		// second reset in mid-run: routing falls back to raw comparators
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		settle();
		chk("latch after second reset", 0, latch_q);
		chk("out1 after second reset", cmp1, out1);
		chk("out2 after second reset", cmp2, out2);
		rdchk("control after second reset", LATCH_CONTROL_OFS, 8'h00);
		report_and_stop();
	end
endmodule // tb_top
